// ### common/wievc_pkg.sv
package wievc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned MS_UNIT       = 1;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * MS_UNIT;
  localparam int unsigned DEEP_STEP_MS  = 16;
  localparam int unsigned DWELL_STEP_MS = 500;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SYS_FLAGS_OFS   = 8'h10;
  localparam logic [7:0] WHEEL_FLAGS_OFS = 8'h14;
  localparam logic [7:0] IDX_OFS         = 8'h18;
  localparam logic [7:0] SETTINGS_OFS    = 8'h70;
  localparam logic [7:0] WAKE_OFS        = 8'h7C;
  localparam logic [7:0] SIZE_OFS        = 8'h7D;
  localparam logic [7:0] OFFS_LO_OFS     = 8'h7E;
  localparam logic [7:0] OFFS_HI_OFS     = 8'h7F;
  localparam logic [7:0] MOVE_OFS        = 8'h8F;
  localparam logic [7:0] GEN_OFS         = 8'hD0;
  localparam logic [7:0] PWR_OFS         = 8'hD2;
  localparam logic [7:0] RATE_NP_OFS     = 8'hD3;
  localparam logic [7:0] RATE_LP_OFS     = 8'hD4;
  localparam logic [7:0] RATE_DS_OFS     = 8'hD5;
  localparam logic [7:0] DWELL_OFS       = 8'hD6;
  localparam logic [7:0] COMM_OFS        = 8'hD9;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  SETTINGS_RST = 8'h14;
  localparam logic [7:0]  WAKE_RST     = 8'h20;
  localparam logic [7:0]  SIZE_RST     = 8'h03;
  localparam logic [15:0] OFFS_RST     = 16'h0000;
  localparam logic [7:0]  GEN_RST      = 8'h00;
  localparam logic [7:0]  PWR_RST      = 8'h00;
  localparam logic [7:0]  RATE_NP_RST  = 8'h0A;
  localparam logic [7:0]  RATE_LP_RST  = 8'h32;
  localparam logic [7:0]  RATE_DS_RST  = 8'h08;
  localparam logic [7:0]  DWELL_RST    = 8'h14;
  localparam logic [7:0]  COMM_RST     = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned ST_ANGLE_OFF = 7;
  localparam int unsigned ST_INT_OFF   = 6;
  localparam int unsigned ST_ZERO      = 5;
  localparam int unsigned ST_WHEEL_DIS = 4;
  localparam int unsigned ST_INT_DIS   = 3;
  localparam int unsigned ST_TOUCH_WK  = 0;
  localparam int unsigned GEN_OSC_HALF = 4;
  localparam int unsigned GEN_EVENT    = 5;
  localparam int unsigned PWR_DEEP_OK  = 6;
  localparam int unsigned PWR_MANUAL   = 5;
  localparam int unsigned PWR_MODE_LO  = 3;
  localparam int unsigned COMM_STREAM  = 5;
  localparam int unsigned FLG_MOVE     = 7;
  localparam int unsigned FLG_DIR      = 6;
  localparam int unsigned SYS_FULL     = 0;

  localparam logic [8:0] DEG_FULL      = 9'h168;
  localparam logic [8:0] DEG_HALF      = 9'h0B4;
  localparam logic [4:0] AWAKE_PRELOAD = 5'h1F;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    PM_NORMAL = 4'h1,
    PM_LOW    = 4'h2,
    PM_DEEP   = 4'h4,
    PM_HALT   = 4'h8
  } wievc_pmode_t;

  typedef struct packed {
    logic touch1;
    logic prox1;
    logic touch0;
    logic prox0;
  } wievc_sense_t;

endpackage

// ### logic/wievc_ctrl.sv
`timescale 1ns/1ns
module wievc_ctrl
  import wievc_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
)(
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic [7:0]   reg_wdata_i,
  output logic      [7:0]   reg_rdata_o,
  input  wire logic         comm_stop_i,
  input  wire logic [8:0]   angle_i,
  input  wire wievc_sense_t sense_i,
  output logic              rdy_n_o,
  output logic              sense_start_o,
  output logic              sense_ch0_only_o,
  output logic              ui_run_o,
  output logic              osc_half_o,
  output wievc_pmode_t      pmode_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [8:0] mod360(input logic [10:0] v);
    logic [10:0] t;
    t = v;
    if (t >= 11'h438)
      t = t - 11'h438;
    if (t >= 11'h2D0)
      t = t - 11'h2D0;
    if (t >= 11'h168)
      t = t - 11'h168;
    return t[8:0];
  endfunction

  // Shortest signed distance from b to a, within -179..180
  function automatic logic signed [9:0] sdist(input logic [8:0] a, input logic [8:0] b);
    logic [8:0] u;
    u = mod360({2'h0, a} + {2'h0, DEG_FULL} - {2'h0, b});
    if (u > DEG_HALF)
      return $signed({1'b0, u}) - $signed({1'b0, DEG_FULL});
    return $signed({1'b0, u});
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]   set_r, wake_r, size_r, gen_r, pwr_r, comm_r;
  logic [7:0]   rate_np_r, rate_lp_r, rate_ds_r, dwell_r;
  logic [7:0]   idx_r, sys_r, flg_r;
  logic [15:0]  offs_r;
  logic [8:0]   zero_r, lo_r, prev_r;
  logic [4:0]   tmr_r;
  logic [2:0]   mcnt_r;
  wievc_pmode_t pm_r;
  logic         tick_r;
  logic         win_r;
  wievc_sense_t sprev_r;

  wire logic wr_any = reg_wr_i;
  wire logic wr_set = reg_wr_i && reg_addr_i == SETTINGS_OFS;
  wire logic wr_idx = reg_wr_i && reg_addr_i == IDX_OFS;
  wire logic wr_wak = reg_wr_i && reg_addr_i == WAKE_OFS;

  // ****************************************
  // Angle and interval tracking
  // ****************************************
  logic [8:0]        adj;
  logic signed [9:0] dint, dmov;
  logic [7:0]        last_idx;
  logic [8:0]        last_lo, next_lo, wr_lo;
  logic [7:0]        wr_idx_v;
  logic [8:0]        mag;
  logic              ui_go, mv_go, inc, dec;

  always_comb
  begin
    adj      = mod360({2'h0, angle_i} + {2'h0, offs_r[8:0]} + 11'h2D0 - {2'h0, zero_r});
    dint     = sdist(adj, lo_r);
    dmov     = sdist(adj, prev_r);
    mag      = dmov[9] ? 9'(-dmov) : dmov[8:0];
    last_idx = (size_r == 8'h00) ? 8'h00 : 8'(9'h167 / {1'b0, size_r});
    last_lo  = 9'(last_idx * size_r);
    next_lo  = 9'({1'b0, lo_r} + {2'h0, size_r});
    wr_idx_v = (reg_wdata_i > last_idx) ? last_idx : reg_wdata_i;
    wr_lo    = 9'(wr_idx_v * size_r);
    ui_go    = tick_r && pm_r == PM_NORMAL && !set_r[ST_ANGLE_OFF];
    mv_go    = tick_r && (pm_r == PM_NORMAL || pm_r == PM_LOW) && !set_r[ST_ANGLE_OFF];
    inc      = ui_go && !set_r[ST_INT_OFF] && dint >= $signed({2'h0, size_r}) + 10'sd1;
    dec      = ui_go && !set_r[ST_INT_OFF] && dint < 10'sd0;
  end

  // Hardware owns the interval tracking, host writes re-anchor it
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idx_r <= 8'h00;
      lo_r  <= 9'h000;
    end
    else if (wr_idx)
    begin
      idx_r <= wr_idx_v;
      lo_r  <= wr_lo;
    end
    else if (inc)
    begin
      if (next_lo >= DEG_FULL || idx_r >= last_idx)
      begin
        idx_r <= 8'h00;
        lo_r  <= 9'h000;
      end
      else
      begin
        idx_r <= idx_r + 8'h01;
        lo_r  <= next_lo;
      end
    end
    else if (dec)
    begin
      if (lo_r < {1'b0, size_r})
      begin
        idx_r <= last_idx;
        lo_r  <= last_lo;
      end
      else
      begin
        idx_r <= idx_r - 8'h01;
        lo_r  <= 9'(lo_r - {1'b0, size_r});
      end
    end
  end

  // ****************************************
  // Movement timer and counter
  // ****************************************
  logic [4:0] pre_v;
  logic [2:0] thr_v;
  logic [3:0] msum;
  logic       mv_evt;

  always_comb
  begin
    pre_v  = wake_r[4:0];
    thr_v  = wake_r[7:5];
    msum   = (mag > 9'h007) ? 4'h7 : 4'({1'b0, mcnt_r} + mag[3:0]);
    if (msum > 4'h7)
      msum = 4'h7;
    mv_evt = mv_go && msum[2:0] >= thr_v && mag != 9'h000;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tmr_r  <= 5'h00;
      mcnt_r <= 3'h0;
      prev_r <= 9'h000;
      flg_r  <= 8'h00;
    end
    else if (mv_go)
    begin
      prev_r <= adj;
      if (mv_evt)
      begin
        mcnt_r          <= 3'h0;
        tmr_r           <= pre_v;
        flg_r[FLG_MOVE] <= 1'b1;
        flg_r[FLG_DIR]  <= !dmov[9];
      end
      else if (pre_v != 5'h00 && tmr_r <= 5'h01)
      begin
        mcnt_r          <= 3'h0;
        tmr_r           <= pre_v;
        flg_r[FLG_MOVE] <= 1'b0;
      end
      else
      begin
        mcnt_r          <= msum[2:0];
        tmr_r           <= (tmr_r == 5'h00) ? 5'h00 : tmr_r - 5'h01;
        flg_r[FLG_MOVE] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Event selection
  // ****************************************
  logic sel_touch, sel_wheel, sel_int;
  logic ev_any, wake_ev, deep_wake, sense_chg, want_win;

  always_comb
  begin
    sel_touch = set_r[ST_TOUCH_WK];
    sel_wheel = !sel_touch && !set_r[ST_WHEEL_DIS];
    sel_int   = !sel_touch && set_r[ST_WHEEL_DIS] && !set_r[ST_INT_DIS];
    sense_chg = tick_r && sense_i != sprev_r;
    if (sel_touch)
      ev_any = tick_r && sense_i.touch0;
    else
      ev_any = (sel_wheel && mv_evt) || (sel_int && (inc || dec)) || sense_chg;
    wake_ev   = sel_touch ? (tick_r && sense_i.touch0) :
                ((sel_wheel && mv_evt) || (sel_int && (inc || dec)));
    deep_wake = tick_r && sense_i.prox0;
    if (pm_r == PM_NORMAL)
      want_win = !gen_r[GEN_EVENT] || comm_r[COMM_STREAM] || ev_any;
    else if (pm_r == PM_LOW)
      want_win = !gen_r[GEN_EVENT] || ev_any;
    else
      want_win = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sprev_r <= '0;
    else if (tick_r)
      sprev_r <= sense_i;
  end

  // ****************************************
  // Report timing
  // ****************************************
  logic [23:0] ms_cnt_r;
  logic [11:0] per_cnt_r, per_tgt;
  logic [9:0]  dw_ms_r;
  logic [7:0]  dw_cnt_r;
  logic [2:0]  full_cnt_r;
  logic        ms_tick, dw_tick, full_upd;

  always_comb
  begin
    ms_tick = ms_cnt_r == 24'(MS_CYC - 1);
    dw_tick = ms_tick && dw_ms_r == 10'(DWELL_STEP_MS - 1);
    case (pm_r)
      PM_NORMAL: per_tgt = {4'h0, rate_np_r};
      PM_LOW:    per_tgt = {4'h0, rate_lp_r};
      PM_DEEP:   per_tgt = 12'(rate_ds_r * DEEP_STEP_MS);
      default:   per_tgt = 12'hFFF;
    endcase
    full_upd = tick_r && pm_r == PM_DEEP && full_cnt_r >= pwr_r[2:0];
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ms_cnt_r  <= 24'h000000;
      per_cnt_r <= 12'h000;
      tick_r    <= 1'b0;
    end
    else
    begin
      ms_cnt_r <= ms_tick ? 24'h000000 : ms_cnt_r + 24'h000001;
      tick_r   <= 1'b0;
      if (pm_r == PM_HALT)
        per_cnt_r <= 12'h000;
      else if (ms_tick)
      begin
        if (per_cnt_r >= per_tgt)
        begin
          per_cnt_r <= 12'h000;
          tick_r    <= 1'b1;
        end
        else
          per_cnt_r <= per_cnt_r + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      full_cnt_r <= 3'h0;
    else if (pm_r != PM_DEEP || full_upd)
      full_cnt_r <= 3'h0;
    else if (tick_r)
      full_cnt_r <= full_cnt_r + 3'h1;
  end

  // ****************************************
  // Power mode sequencing
  // ****************************************
  wievc_pmode_t man_pm;
  logic         dw_done;

  always_comb
  begin
    case (pwr_r[PWR_MODE_LO +: 2])
      2'h0:    man_pm = PM_NORMAL;
      2'h1:    man_pm = PM_LOW;
      2'h2:    man_pm = pwr_r[PWR_DEEP_OK] ? PM_DEEP : PM_LOW;
      default: man_pm = PM_HALT;
    endcase
    dw_done = dw_cnt_r >= dwell_r;
  end

  // Dwell restarts on any selected event, deep wake or register write so the part only sinks after quiet time
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dw_ms_r  <= 10'h000;
      dw_cnt_r <= 8'h00;
    end
    else if (ev_any || wake_ev || deep_wake || wr_any)
    begin
      dw_ms_r  <= 10'h000;
      dw_cnt_r <= 8'h00;
    end
    else if (ms_tick)
    begin
      dw_ms_r <= dw_tick ? 10'h000 : dw_ms_r + 10'h001;
      if (dw_tick && !dw_done)
        dw_cnt_r <= dw_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pm_r <= PM_NORMAL;
    else if (pwr_r[PWR_MANUAL])
      pm_r <= man_pm;
    else
    begin
      case (pm_r)
        PM_NORMAL:
          if (dw_done && dw_tick)
            pm_r <= PM_LOW;
        PM_LOW:
          if (wake_ev)
            pm_r <= PM_NORMAL;
          else if (dw_done && dw_tick && pwr_r[PWR_DEEP_OK])
            pm_r <= PM_DEEP;
        PM_DEEP:
          if (deep_wake || wake_ev)
            pm_r <= PM_NORMAL;
        // Halt is left only through a manual mode write
        PM_HALT: pm_r <= PM_HALT;
        default: pm_r <= PM_NORMAL;
      endcase
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      size_r    <= SIZE_RST;
      gen_r     <= GEN_RST;
      pwr_r     <= PWR_RST;
      comm_r    <= COMM_RST;
      rate_np_r <= RATE_NP_RST;
      rate_lp_r <= RATE_LP_RST;
      rate_ds_r <= RATE_DS_RST;
      dwell_r   <= DWELL_RST;
      offs_r    <= OFFS_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == SIZE_OFS)
        size_r <= reg_wdata_i;
      else if (reg_addr_i == GEN_OFS)
        gen_r <= reg_wdata_i;
      else if (reg_addr_i == PWR_OFS)
        pwr_r <= reg_wdata_i;
      else if (reg_addr_i == COMM_OFS)
        comm_r <= reg_wdata_i;
      else if (reg_addr_i == RATE_NP_OFS)
        rate_np_r <= reg_wdata_i;
      else if (reg_addr_i == RATE_LP_OFS)
        rate_lp_r <= reg_wdata_i;
      else if (reg_addr_i == RATE_DS_OFS)
        rate_ds_r <= reg_wdata_i;
      else if (reg_addr_i == DWELL_OFS)
        dwell_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      set_r  <= SETTINGS_RST;
      zero_r <= 9'h000;
    end
    else if (wr_set)
      set_r <= reg_wdata_i;
    else if (set_r[ST_ZERO])
    begin
      zero_r           <= angle_i;
      set_r[ST_ZERO]   <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wake_r <= WAKE_RST;
    else if (pm_r == PM_NORMAL && wake_r[4:0] == 5'h00 && wake_ev)
      wake_r[4:0] <= AWAKE_PRELOAD;
    else if (wr_wak)
      wake_r <= reg_wdata_i;
  end

  // Full-update flag clears on read, a new update in that cycle wins
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sys_r <= 8'h00;
    else if (full_upd)
      sys_r[SYS_FULL] <= 1'b1;
    else if (reg_rd_i && reg_addr_i == SYS_FLAGS_OFS)
      sys_r[SYS_FULL] <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      if (reg_addr_i == SYS_FLAGS_OFS)
        reg_rdata_o <= sys_r;
      else if (reg_addr_i == WHEEL_FLAGS_OFS)
        reg_rdata_o <= flg_r;
      else if (reg_addr_i == IDX_OFS)
        reg_rdata_o <= idx_r;
      else if (reg_addr_i == SETTINGS_OFS)
        reg_rdata_o <= set_r;
      else if (reg_addr_i == WAKE_OFS)
        reg_rdata_o <= wake_r;
      else if (reg_addr_i == SIZE_OFS)
        reg_rdata_o <= size_r;
      else if (reg_addr_i == OFFS_LO_OFS)
        reg_rdata_o <= offs_r[7:0];
      else if (reg_addr_i == OFFS_HI_OFS)
        reg_rdata_o <= offs_r[15:8];
      else if (reg_addr_i == MOVE_OFS)
        reg_rdata_o <= {mcnt_r, tmr_r};
      else if (reg_addr_i == GEN_OFS)
        reg_rdata_o <= gen_r;
      else if (reg_addr_i == PWR_OFS)
        reg_rdata_o <= pwr_r;
      else if (reg_addr_i == RATE_NP_OFS)
        reg_rdata_o <= rate_np_r;
      else if (reg_addr_i == RATE_LP_OFS)
        reg_rdata_o <= rate_lp_r;
      else if (reg_addr_i == RATE_DS_OFS)
        reg_rdata_o <= rate_ds_r;
      else if (reg_addr_i == DWELL_OFS)
        reg_rdata_o <= dwell_r;
      else if (reg_addr_i == COMM_OFS)
        reg_rdata_o <= comm_r;
      else
        reg_rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // Ready window and sensing outputs
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      win_r <= 1'b0;
    else if (comm_stop_i)
      win_r <= 1'b0;
    else if (tick_r && want_win)
      win_r <= 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdy_n_o          <= 1'b1;
      sense_start_o    <= 1'b0;
      sense_ch0_only_o <= 1'b0;
      ui_run_o         <= 1'b0;
      osc_half_o       <= 1'b0;
      pmode_o          <= PM_NORMAL;
    end
    else
    begin
      rdy_n_o          <= !win_r;
      sense_start_o    <= tick_r;
      sense_ch0_only_o <= pm_r == PM_DEEP && !full_upd;
      ui_run_o         <= pm_r == PM_NORMAL && !set_r[ST_ANGLE_OFF];
      osc_half_o       <= gen_r[GEN_OSC_HALF];
      pmode_o          <= pm_r;
    end
  end

endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench
  import wievc_pkg::*;
;
  logic mclk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, comm_stop_i;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [8:0] angle_i = 9'h000;
  wievc_sense_t sense_i = '0;
  logic rdy_n_o, sense_start_o, sense_ch0_only_o, ui_run_o, osc_half_o;
  wievc_pmode_t pmode_o;
  int wins, n, mismatches = 0, tests_run = 0;
  logic [8:0] ang[4] = '{9'h088, 9'h089, 9'h088, 9'h087};
  logic c0;
  logic [7:0] idx[4] = '{8'h00, 8'h01, 8'h01, 8'h00};
  logic [7:0] pw[5] = '{8'h38, 8'h28, 8'h71, 8'h30, 8'h20};
  logic [3:0] pmx[5] = '{4'h8, 4'h2, 4'h4, 4'h2, 4'h1};
  always #50 mclk_i = ~mclk_i;
  wievc_ctrl #(.MS_CYC(10)) dut_u (.mclk_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .comm_stop_i, .angle_i, .sense_i, .rdy_n_o, .sense_start_o, .sense_ch0_only_o,
    .ui_run_o, .osc_half_o, .pmode_o);
  wievc_host #(.HOLD(3)) host_u (.clk_i(mclk_i), .rstn_i, .rdy_n_i(rdy_n_o), .stop_o(comm_stop_i), .wins_o(wins));
  // ****************
  // Access tasks
  // ****************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    chk(what, {8'h00, e}, {8'h00, reg_rdata_o});
  endtask
  task automatic test_done;
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    cyc(12);
    rstn_i <= 1'b1;
    rdc(SIZE_OFS, 8'h03, "size");
    wr(OFFS_HI_OFS, 8'h12);
    rdc(OFFS_HI_OFS, 8'h00, "offset");
    rdc(8'h00, 8'h00, "unmapped");
    wr(RATE_NP_OFS, 8'h00);
    for (n = 0; n < 200 && rdy_n_o !== 1'b0; n++) cyc(1);
    chk("ready", 16'h0000, {15'h0, rdy_n_o});
    if (rdy_n_o !== 1'b0) test_done();
    angle_i <= 9'h064;
    wr(SIZE_OFS, 8'h24);
    wr(SETTINGS_OFS, 8'h34);
    cyc(30);
    rdc(SETTINGS_OFS, 8'h14, "zero bit");
    wr(GEN_OFS, 8'h20);
    cyc(30);
    n = wins;
    for (int k = 0; k < 4; k++)
    begin
      angle_i <= ang[k];
      cyc(40);
      rdc(IDX_OFS, idx[k], "index");
    end
    chk("interval windows", 16'h0002, 16'(wins - n));
    wr(SETTINGS_OFS, 8'h1C);
    n = wins;
    angle_i <= 9'h089;
    cyc(40);
    chk("suppressed", 16'h0000, 16'(wins - n));
    wr(SETTINGS_OFS, 8'h1D);
    sense_i.touch0 <= 1'b1;
    n = wins;
    cyc(60);
    chk("touch repeat", 16'h0001, {15'h0, wins - n > 2});
    sense_i.touch0 <= 1'b0;
    cyc(20);
    n = wins;
    cyc(60);
    chk("touch gone", 16'h0000, 16'(wins - n));
    wr(COMM_OFS, 8'h20);
    n = wins;
    cyc(60);
    chk("stream", 16'h0001, {15'h0, wins - n > 2});
    wr(COMM_OFS, 8'h00);
    wr(RATE_DS_OFS, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      wr(PWR_OFS, pw[k]);
      cyc(39);
      c0 = sense_ch0_only_o;
      cyc(1);
      chk("mode", {12'h0, pmx[k]}, {12'h0, pmode_o});
      // A full update drops ch0 only for one cycle, so two samples cover it
      chk("ch0 only", {15'h0, k == 2}, {15'h0, c0 | sense_ch0_only_o});
      if (k == 2) rdc(SYS_FLAGS_OFS, 8'h01, "full update");
    end
    wr(GEN_OFS, 8'h30);
    cyc(2);
    chk("osc half", 16'h0001, {15'h0, osc_half_o});
    wr(DWELL_OFS, 8'h00);
    wr(PWR_OFS, 8'h00);
    cyc(4980);
    chk("dwell hold", {12'h0, PM_NORMAL}, {12'h0, pmode_o});
    cyc(30);
    chk("dwell sink", {12'h0, PM_LOW}, {12'h0, pmode_o});
    test_done();
  end
endmodule

// ### testbench/wievc_checker.sv
`timescale 1ns/1ns
module wievc_checker
  import wievc_pkg::*;
(
  input wire logic         mclk_i,
  input wire logic         rstn_i,
  input wire logic         reg_wr_i,
  input wire logic         reg_rd_i,
  input wire logic [7:0]   reg_addr_i,
  input wire logic [7:0]   reg_wdata_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire logic         comm_stop_i,
  input wire logic [8:0]   angle_i,
  input wire wievc_sense_t sense_i,
  input wire logic         rdy_n_o,
  input wire logic         sense_start_o,
  input wire logic         sense_ch0_only_o,
  input wire logic         ui_run_o,
  input wire logic         osc_half_o,
  input wire wievc_pmode_t pmode_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  stop_close_a: assert property (comm_stop_i |-> ##2 rdy_n_o)
    else $error("ready not released after stop");
  offs_ro_a: assert property (reg_rd_i && reg_addr_i[7:1] == 7'h3F |=> reg_rdata_o == 8'h00)
    else $error("offset byte not zero");
  osc_copy_a: assert property (reg_wr_i && reg_addr_i == GEN_OFS |-> ##2 osc_half_o == $past(reg_wdata_i[4], 2))
    else $error("oscillator select wrong");
  deep_ch0_a: assert property ($rose(sense_ch0_only_o) |-> ##[0:1] pmode_o == PM_DEEP)
    else $error("channel 0 only outside deep sleep");
  halt_quiet_a: assert property ((pmode_o == PM_HALT) [*3] |-> !sense_start_o)
    else $error("sensing in halt");
  low_noui_a: assert property ((pmode_o == PM_LOW) [*2] |-> !ui_run_o)
    else $error("wheel processing in low power");
  mode_hot_a: assert property ($onehot(pmode_o))
    else $error("power mode not one-hot");
  tick_gap_a: assert property (sense_start_o |=> !sense_start_o [*8])
    else $error("report cycles too close");
  cover property ($fell(rdy_n_o));
  cover property (pmode_o == PM_HALT);
  cover property (pmode_o == PM_DEEP);
endmodule
bind wievc_ctrl wievc_checker chk_u (.mclk_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o, .comm_stop_i, .angle_i, .sense_i, .rdy_n_o, .sense_start_o, .sense_ch0_only_o, .ui_run_o,
  .osc_half_o, .pmode_o);

// ### testbench/wievc_host.sv
`timescale 1ns/1ns
module wievc_host #(
  parameter int HOLD = 3
)(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic rdy_n_i,
  output logic      stop_o,
  output int        wins_o
);
  int cnt;
  // Host answers each window after HOLD cycles with a STOP
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt    <= 0;
      stop_o <= 1'b0;
      wins_o <= 0;
    end
    else
    begin
      stop_o <= 1'b0;
      if (rdy_n_i)
        cnt <= 0;
      else if (cnt < HOLD)
        cnt <= cnt + 1;
      else if (cnt == HOLD)
      begin
        stop_o <= 1'b1;
        wins_o <= wins_o + 1;
        cnt    <= HOLD + 1;
      end
    end
  end
endmodule
